// ===== pin_change_pkg.sv
// constants and types for the pin change edge detector
package pin_change_pkg;

    // register bus geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    // register offsets (one byte register per address)
    localparam logic [3:0] OFS_PORTA_RISE   = 4'h0;
    localparam logic [3:0] OFS_PORTA_FALL   = 4'h1;
    localparam logic [3:0] OFS_PORTA_FLAGS  = 4'h2;
    localparam logic [3:0] OFS_PORTB_RISE   = 4'h3;
    localparam logic [3:0] OFS_PORTB_FALL   = 4'h4;
    localparam logic [3:0] OFS_PORTB_FLAGS  = 4'h5;
    localparam logic [3:0] OFS_PORTC_RISE   = 4'h6;
    localparam logic [3:0] OFS_PORTC_FALL   = 4'h7;
    localparam logic [3:0] OFS_PORTC_FLAGS  = 4'h8;
    localparam logic [3:0] OFS_PORTE_RISE   = 4'h9;
    localparam logic [3:0] OFS_PORTE_FALL   = 4'hA;
    localparam logic [3:0] OFS_PORTE_FLAGS  = 4'hB;
    localparam logic [3:0] OFS_IRQ_CTRL     = 4'hC;
    localparam logic [3:0] OFS_IRQ_STATUS   = 4'hD;
    localparam logic [3:0] OFS_IRQ_CLEAR    = 4'hE;
    localparam logic [3:0] OFS_IRQ_ENABLE   = 4'hF;

    // port E implements only bit 3
    localparam logic [7:0] PORTE_MASK   = 8'h08;
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [7:0] READ_ZERO    = 8'h00;

    // port indexing and register kinds within a port
    localparam logic [3:0] REGS_PER_PORT = 4'h3;
    localparam logic [2:0] PORT_NONE     = 3'h4;
    localparam logic [1:0] KIND_RISE     = 2'h0;
    localparam logic [1:0] KIND_FALL     = 2'h1;
    localparam logic [1:0] KIND_FLAGS    = 2'h2;
    localparam logic [7:0] FULL_MASK     = 8'hFF;

    // irq control register fields
    localparam int unsigned CTRL_IRQ_EN_BIT = 0;

    // event status bits: one per port
    localparam int unsigned EV_W      = 4;
    localparam int unsigned EV_PORTA  = 0;
    localparam int unsigned EV_PORTB  = 1;
    localparam int unsigned EV_PORTC  = 2;
    localparam int unsigned EV_PORTE  = 3;
    localparam logic [3:0]  EV_RESET  = 4'h0;

endpackage : pin_change_pkg

// ===== pin_change_edge_detector.sv
// pin change edge detector with register port and level interrupt
`timescale 1ns/1ns
module pin_change_edge_detector
    import pin_change_pkg::*;
(
    // clock, reset, enable
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // external pins
    input  wire logic [7:0]        porta_pin,
    input  wire logic [7:0]        portb_pin,
    input  wire logic [7:0]        portc_pin,
    input  wire logic [7:0]        porte_pin,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output      logic [DATA_W-1:0] reg_rdata,
    // interrupt
    output      logic              pin_change_irq_flag,
    output      logic              pin_change_irq,
    output      logic              irq
);

    // per-port storage: index 0 A, 1 B, 2 C, 3 E
    logic [7:0] rise_en   [4];
    logic [7:0] fall_en   [4];
    logic [7:0] flags     [4];
    logic [7:0] pin_prev  [4];
    logic [7:0] pin_now   [4];
    logic [7:0] impl_mask [4];
    logic [7:0] edge_hit  [4];
    logic       pin_change_irq_en;
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_enable;
    logic [EV_W-1:0] ev_pulse;
    logic       pins_valid;

    // port index of a register address, or 4 when not a per-port register
    function automatic logic [2:0] port_of(input logic [3:0] a);
        port_of = (a < OFS_IRQ_CTRL) ? 3'(a / REGS_PER_PORT) : PORT_NONE;
    endfunction : port_of

    // kind within a port: 0 rise, 1 fall, 2 flags
    function automatic logic [1:0] kind_of(input logic [3:0] a);
        kind_of = 2'(a % REGS_PER_PORT);
    endfunction : kind_of

    // pin vectors and implemented-bit masks
    always_comb begin
        pin_now[0]   = porta_pin;
        pin_now[1]   = portb_pin;
        pin_now[2]   = portc_pin;
        pin_now[3]   = porte_pin;
        impl_mask[0] = FULL_MASK;
        impl_mask[1] = FULL_MASK;
        impl_mask[2] = FULL_MASK;
        impl_mask[3] = PORTE_MASK;
    end

    // edge detection against the last sample
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            edge_hit[p] = ((rise_en[p] & pin_now[p] & ~pin_prev[p])
                         | (fall_en[p] & ~pin_now[p] & pin_prev[p]))
                         & impl_mask[p] & {8{pins_valid}};
        end
    end

    // pin history; first sample after reset only primes it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins_valid <= 1'b0;
            for (int p = 0; p < 4; p++) pin_prev[p] <= REG_RESET;
        end else if (clk_en) begin
            pins_valid <= 1'b1;
            for (int p = 0; p < 4; p++) pin_prev[p] <= pin_now[p];
        end
    end

    // edge enable registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int p = 0; p < 4; p++) begin
                rise_en[p] <= REG_RESET;
                fall_en[p] <= REG_RESET;
            end
        end else if (clk_en && reg_write && port_of(reg_addr) < PORT_NONE) begin
            for (int p = 0; p < 4; p++) begin
                if (port_of(reg_addr) == 3'(p) && kind_of(reg_addr) == KIND_RISE)
                    rise_en[p] <= reg_wdata & impl_mask[p];
                if (port_of(reg_addr) == 3'(p) && kind_of(reg_addr) == KIND_FALL)
                    fall_en[p] <= reg_wdata & impl_mask[p];
            end
        end
    end

    // change flags: hardware sets, software writes zero to clear, set wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int p = 0; p < 4; p++) flags[p] <= REG_RESET;
        end else if (clk_en) begin
            for (int p = 0; p < 4; p++) begin
                if (reg_write && port_of(reg_addr) == 3'(p) && kind_of(reg_addr) == KIND_FLAGS)
                    flags[p] <= ((flags[p] & reg_wdata) | edge_hit[p]) & impl_mask[p];
                else
                    flags[p] <= flags[p] | edge_hit[p];
            end
        end
    end

    // shared flag and gated request
    assign pin_change_irq_flag = |{flags[0], flags[1], flags[2], flags[3]};
    assign pin_change_irq      = pin_change_irq_flag & pin_change_irq_en;

    // per-port event pulses for sticky status
    always_comb begin
        for (int p = 0; p < EV_W; p++) ev_pulse[p] = |edge_hit[p];
    end

    // irq control, sticky status, status enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_change_irq_en <= 1'b0;
            ev_status         <= EV_RESET;
            ev_enable         <= EV_RESET;
        end else if (clk_en) begin
            if (reg_write && reg_addr == OFS_IRQ_CTRL)
                pin_change_irq_en <= reg_wdata[CTRL_IRQ_EN_BIT];
            if (reg_write && reg_addr == OFS_IRQ_ENABLE)
                ev_enable <= reg_wdata[EV_W-1:0];
            if (reg_write && reg_addr == OFS_IRQ_CLEAR)
                ev_status <= (ev_status & ~reg_wdata[EV_W-1:0]) | ev_pulse;
            else
                ev_status <= ev_status | ev_pulse;
        end
    end

    assign irq = |(ev_status & ev_enable);

    // read data, valid the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= READ_ZERO;
        end else if (clk_en) begin
            reg_rdata <= READ_ZERO;
            if (reg_read) begin
                case (reg_addr)
                    OFS_IRQ_CTRL:   reg_rdata <= {7'h00, pin_change_irq_en};
                    OFS_IRQ_STATUS: reg_rdata <= {4'h0, ev_status};
                    OFS_IRQ_CLEAR:  reg_rdata <= READ_ZERO;
                    OFS_IRQ_ENABLE: reg_rdata <= {4'h0, ev_enable};
                    default: begin
                        for (int p = 0; p < 4; p++) begin
                            if (port_of(reg_addr) == 3'(p)) begin
                                case (kind_of(reg_addr))
                                    KIND_RISE: reg_rdata <= rise_en[p] & impl_mask[p];
                                    KIND_FALL: reg_rdata <= fall_en[p] & impl_mask[p];
                                    default: reg_rdata <= flags[p] & impl_mask[p];
                                endcase
                            end
                        end
                    end
                endcase
            end
        end
    end

    // assertions and covers
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_porte_fall_sets: assert property (
        clk_en && pins_valid && fall_en[3][3] && pin_prev[3][3] && !porte_pin[3]
        |=> flags[3][3] && pin_change_irq_flag)
        else $error("enabled port E falling edge did not set flag");

    a_disabled_no_set: assert property (
        clk_en && !flags[0][0] && !(reg_write && port_of(reg_addr) == 3'h0)
        && !rise_en[0][0] && !fall_en[0][0] |=> !flags[0][0])
        else $error("flag set with both enables clear");

    a_porte_rise_sets: assert property (
        clk_en && pins_valid && rise_en[3][3] && !pin_prev[3][3] && porte_pin[3]
        |=> flags[3][3])
        else $error("enabled port E rising edge did not set flag");

    a_flag_write_clear: assert property (
        clk_en && reg_write && reg_addr == OFS_PORTA_FLAGS && reg_wdata == 8'h00
        && edge_hit[0] == 8'h00 |=> flags[0] == 8'h00)
        else $error("writing zero did not clear flags");

    a_porte_unimpl_zero: assert property (
        (rise_en[3] & ~PORTE_MASK) == 8'h00 && (fall_en[3] & ~PORTE_MASK) == 8'h00
        && (flags[3] & ~PORTE_MASK) == 8'h00)
        else $error("unimplemented port E bit is set");

    a_reset_clears: assert property (
        @(posedge clk) disable iff (1'b0) !rst_n |=> flags[3] == 8'h00
        && rise_en[3] == 8'h00 && fall_en[3] == 8'h00 && !irq)
        else $error("reset left state nonzero");

    a_rise_sets_flag: assert property (
        clk_en && pins_valid && rise_en[1][5] && !pin_prev[1][5] && portb_pin[5]
        |=> flags[1][5])
        else $error("enabled rising edge did not set flag");

    a_flag_sticky: assert property (
        clk_en && flags[2][4] && !(reg_write && reg_addr == OFS_PORTC_FLAGS)
        |=> flags[2][4])
        else $error("flag cleared without a software write");

    a_irq_gating: assert property (
        pin_change_irq == (pin_change_irq_en && pin_change_irq_flag))
        else $error("request not gated by enable");

    a_read_latency: assert property (
        clk_en && reg_read && reg_addr == OFS_IRQ_CTRL
        |=> reg_rdata == {7'h00, $past(pin_change_irq_en)})
        else $error("control readback wrong");

    // freeze, bus, write and status checks
    a_freeze_holds: assert property (
        !clk_en |=> $stable(flags[3]) && $stable(rise_en[3]) && $stable(pin_prev[3])
        && $stable(pins_valid) && $stable(ev_status) && $stable(reg_rdata))
        else $error("state moved while clock enable low");

    a_porte_no_spurious: assert property (
        clk_en && !flags[3][3]
        && !(rise_en[3][3] && !pin_prev[3][3] && porte_pin[3])
        && !(fall_en[3][3] && pin_prev[3][3] && !porte_pin[3])
        |=> !flags[3][3])
        else $error("port E flag set without an enabled edge");

    a_porte_write_clear: assert property (
        clk_en && reg_write && reg_addr == OFS_PORTE_FLAGS && !reg_wdata[3]
        && pin_prev[3][3] == porte_pin[3] |=> !flags[3][3])
        else $error("writing zero did not clear port E flag");

    a_no_soft_set: assert property (
        clk_en && !flags[2][1] && pin_prev[2][1] == portc_pin[1]
        |=> !flags[2][1])
        else $error("flag set by a register write");

    a_unimpl_read_zero: assert property (
        clk_en && reg_read && (reg_addr == OFS_PORTE_RISE || reg_addr == OFS_PORTE_FALL
        || reg_addr == OFS_PORTE_FLAGS) |=> (reg_rdata & ~PORTE_MASK) == READ_ZERO)
        else $error("unimplemented port E bit read nonzero");

    a_rise_en_write: assert property (
        clk_en && reg_write && reg_addr == OFS_PORTC_RISE
        |=> rise_en[2] == $past(reg_wdata))
        else $error("port C rising enable write lost");

    a_fall_en_write: assert property (
        clk_en && reg_write && reg_addr == OFS_PORTE_FALL
        |=> fall_en[3] == ($past(reg_wdata) & PORTE_MASK))
        else $error("port E falling enable write wrong");

    a_fall_sets_flag: assert property (
        clk_en && pins_valid && fall_en[0][6] && pin_prev[0][6] && !porta_pin[6]
        |=> flags[0][6])
        else $error("enabled falling edge did not set flag");

    a_shared_flag_holds: assert property (
        clk_en && pin_change_irq_flag && !reg_write |=> pin_change_irq_flag)
        else $error("shared flag dropped while pin flags set");

    a_status_sets_irq: assert property (
        clk_en && pins_valid && ev_enable[EV_PORTE] && fall_en[3][3] && pin_prev[3][3]
        && !porte_pin[3] && !(reg_write && reg_addr == OFS_IRQ_ENABLE) |=> irq)
        else $error("enabled port event did not raise irq");

    a_status_clear: assert property (
        clk_en && reg_write && reg_addr == OFS_IRQ_CLEAR && reg_wdata[EV_PORTA]
        && edge_hit[0] == 8'h00 |=> !ev_status[EV_PORTA])
        else $error("status clear did not clear port A bit");

    a_rdata_idle_zero: assert property (
        clk_en && !reg_read |=> reg_rdata == READ_ZERO)
        else $error("read data stood past its cycle");

    c_porte_fall: cover property (clk_en && edge_hit[3][3]);
    c_irq_raised: cover property (!pin_change_irq ##1 pin_change_irq);
    c_clear_vs_set: cover property (
        reg_write && reg_addr == OFS_PORTA_FLAGS && edge_hit[0] != 8'h00);
    c_status_irq: cover property (!irq ##1 irq);
    c_flag_cleared: cover property (flags[3][3] ##1 !flags[3][3]);

endmodule : pin_change_edge_detector

// ===== pin_levels_model.sv
// external pin levels seen by the edge detector
`timescale 1ns/1ns
module pin_levels_model (
    // clock
    input  wire logic        clk,
    // requested levels, port e in the top byte
    input  wire logic [31:0] want,
    // pins
    output      logic [7:0]  porta_pin,
    output      logic [7:0]  portb_pin,
    output      logic [7:0]  portc_pin,
    output      logic [7:0]  porte_pin
);
    // pins follow the request one edge later, like real pad timing
    always_ff @(posedge clk) begin
        {porte_pin, portc_pin, portb_pin, porta_pin} <= want;
    end
endmodule : pin_levels_model

// ===== pin_change_edge_detector_bench.sv
// self-checking bench for the pin change edge detector
`timescale 1ns/1ns
module pin_change_edge_detector_bench;
    import pin_change_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        clk_en;
    logic [31:0] want;
    logic [7:0]  pa, pb, pc, pe;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic        reg_write, reg_read;
    logic        irq_flag, pin_change_irq, irq;
    int          bad_count, compares;

    pin_levels_model i_pins (.clk(clk), .want(want), .porta_pin(pa), .portb_pin(pb),
        .portc_pin(pc), .porte_pin(pe));
    pin_change_edge_detector i_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .porta_pin(pa), .portb_pin(pb), .portc_pin(pc), .porte_pin(pe),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_change_irq_flag(irq_flag),
        .pin_change_irq(pin_change_irq), .irq(irq));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic end_of_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a; reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rdchk

    task automatic pins(input int p, input logic [7:0] v);
        @(posedge clk);
        want[8*p +: 8] <= v;
        repeat (3) @(posedge clk);
    endtask : pins

    task automatic t_reset();
        for (int a = 0; a < 16; a++) rdchk(4'(a), 8'h00);
        chk({5'h00, irq_flag, pin_change_irq, irq}, 8'h00);
    endtask : t_reset

    task automatic t_porte_bits();
        wr(OFS_PORTE_RISE, 8'hFF);
        wr(OFS_PORTE_FALL, 8'hFF);
        wr(OFS_PORTE_FLAGS, 8'hFF);
        rdchk(OFS_PORTE_RISE, 8'h08);
        rdchk(OFS_PORTE_FALL, 8'h08);
        rdchk(OFS_PORTE_FLAGS, 8'h00);
        wr(OFS_PORTE_RISE, 8'h00);
        wr(OFS_PORTE_FALL, 8'h00);
    endtask : t_porte_bits

    // ports a, b, c: upper nibble rise, lower nibble fall
    task automatic t_ports();
        for (int p = 0; p < 3; p++) begin
            wr(4'(3*p), 8'hF0);
            wr(4'(3*p+1), 8'h0F);
            pins(p, 8'hFF);
            rdchk(4'(3*p+2), 8'hF0);
            pins(p, 8'h00);
            rdchk(4'(3*p+2), 8'hFF);
            chk({7'h00, irq_flag}, 8'h01);
            wr(4'(3*p+2), 8'h0F);
            rdchk(4'(3*p+2), 8'h0F);
            wr(4'(3*p+2), 8'h00);
            rdchk(4'(3*p+2), 8'h00);
        end
        chk({7'h00, irq_flag}, 8'h00);
        rdchk(OFS_IRQ_STATUS, 8'h07);
        wr(OFS_IRQ_CLEAR, 8'h0F);
        rdchk(OFS_IRQ_STATUS, 8'h00);
    endtask : t_ports

    task automatic t_porte();
        wr(OFS_PORTE_FALL, 8'h08);
        pins(3, 8'h08);
        rdchk(OFS_PORTE_FLAGS, 8'h00);
        pins(3, 8'h00);
        rdchk(OFS_PORTE_FLAGS, 8'h08);
        chk({7'h00, irq_flag}, 8'h01);
        wr(OFS_PORTE_FLAGS, 8'h00);
        rdchk(OFS_PORTE_FLAGS, 8'h00);
        wr(OFS_PORTE_RISE, 8'h08);
        wr(OFS_PORTE_FALL, 8'h00);
        pins(3, 8'h08);
        rdchk(OFS_PORTE_FLAGS, 8'h08);
    endtask : t_porte

    task automatic t_irq();
        chk({7'h00, pin_change_irq}, 8'h00);
        wr(OFS_IRQ_CTRL, 8'h01);
        chk({7'h00, pin_change_irq}, 8'h01);
        rdchk(OFS_IRQ_STATUS, 8'h08);
        chk({7'h00, irq}, 8'h00);
        wr(OFS_IRQ_ENABLE, 8'h08);
        chk({7'h00, irq}, 8'h01);
        wr(OFS_IRQ_CLEAR, 8'h08);
        chk({7'h00, irq}, 8'h00);
        rdchk(OFS_IRQ_CLEAR, 8'h00);
        wr(OFS_PORTE_FLAGS, 8'h00);
        chk({7'h00, pin_change_irq}, 8'h00);
    endtask : t_irq

    // clock enable low freezes pin history and flags; edge seen on resume
    task automatic t_freeze();
        wr(OFS_PORTE_FALL, 8'h08);
        @(posedge clk);
        clk_en <= 1'b0;
        want[31:24] <= 8'h00;
        repeat (4) @(posedge clk);
        #1 chk({7'h00, irq_flag}, 8'h00);
        @(posedge clk);
        clk_en <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({7'h00, irq_flag}, 8'h01);
        rdchk(OFS_PORTE_FLAGS, 8'h08);
        wr(OFS_PORTE_FLAGS, 8'h00);
        rdchk(OFS_PORTE_FLAGS, 8'h00);
    endtask : t_freeze

    // reset in mid-run clears port e state
    task automatic t_rereset();
        pins(3, 8'h00);
        rdchk(OFS_PORTE_FLAGS, 8'h00);
        pins(3, 8'h08);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(OFS_PORTE_RISE, 8'h00);
        rdchk(OFS_PORTE_FLAGS, 8'h00);
        chk({5'h00, irq_flag, pin_change_irq, irq}, 8'h00);
    endtask : t_rereset

    // main sequence
    initial begin
        rst_n = 1'b0; clk_en = 1'b1; want = '0;
        reg_addr = 4'h0; reg_wdata = 8'h00; reg_write = 1'b0; reg_read = 1'b0;
        bad_count = 0; compares = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_porte_bits();
        t_ports();
        t_porte();
        t_irq();
        t_freeze();
        t_rereset();
        end_of_test();
    end

    // watchdog
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
endmodule : pin_change_edge_detector_bench
